// ### interrupt_pending_service_logic.sv
// Interrupt controller core: pending, in-service, mask, threshold, poll
// Assumes per-source control registers outside supply priorities
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "intc_regs.svh"

module interrupt_pending_service_logic
  import intc_pkg::*;
#(
  parameter int EXT_PINS = 5
) (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst_b,
  // Register port
  input  wire logic [7:0]            reg_addr,
  input  wire logic [15:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [15:0]           reg_rdata,
  // Peripheral requests
  input  wire logic [2:0]            timer_req,
  input  wire logic [1:0]            dma_req,
  input  wire logic [6:0]            serial_zero_status,
  input  wire logic [6:0]            serial_one_status,
  input  wire logic [1:0]            serial_enable,
  input  wire logic [EXT_PINS-1:0]   external_request_pins,
  // Per-source control registers
  input  wire logic [32:0]           source_priority_field,
  input  wire logic [10:0]           ctl_mask_wr,
  input  wire logic [10:0]           ctl_mask_wdata,
  output logic      [10:0]           source_disable_bit,
  // Mode and processor core
  input  wire logic                  slave_mode_sel,
  input  wire logic                  core_ack,
  output logic                       int_request,
  output logic      [4:0]            int_type
);

  localparam int NSRC = 13;

  // Refuse pin counts the bit layout cannot hold
  if (EXT_PINS != 5) begin : g_chk
    $error("EXT_PINS must be 5");
  end

  // Pick lowest priority code among set bits, lowest index on a tie
  function automatic logic [4:0] pick_top(input src_vec_t v,
                                          input logic [3*NSRC-1:0] pr);
    logic [2:0] lvl;
    logic [4:0] res;
    lvl = 3'h7;
    res = 5'h00;
    for (int i = 0; i < NSRC; i++) begin
      if (v[i] && (!res[4] || pr[3*i+:3] < lvl)) begin
        lvl = pr[3*i+:3];
        res = {1'b1, 4'(i)};
      end
    end
    return res;
  endfunction : pick_top

  // Map internal source vector onto the register bit layout
  function automatic logic [15:0] reg_view(input src_vec_t v,
                                           input logic sl);
    logic [15:0] r;
    r = 16'h0000;
    if (sl) begin
      r[0]   = v[0];
      r[3:2] = v[3:2];
      r[4]   = v[11];
      r[5]   = v[12];
    end else begin
      r[10:2] = v[10:2];
      r[0] = v[0] | v[11] | v[12];
    end
    return r;
  endfunction : reg_view

  // Interrupt type of each internal source in master mode
  function automatic vec_type_t master_type(input int i);
    case (i)
      0:       master_type = `TYPE_TMR0;
      2:       master_type = `TYPE_DMA0;
      3:       master_type = `TYPE_DMA1;
      4:       master_type = `TYPE_EXT0;
      5:       master_type = `TYPE_EXT1;
      6:       master_type = `TYPE_EXT2;
      7:       master_type = `TYPE_EXT3;
      8:       master_type = `TYPE_EXT4;
      9:       master_type = `TYPE_SER1;
      10:      master_type = `TYPE_SER0;
      11:      master_type = `TYPE_TMR1;
      12:      master_type = `TYPE_TMR2;
      default: master_type = 5'h00;
    endcase
  endfunction : master_type

  // Low type bits in slave mode; upper bits come from elsewhere
  function automatic vec_type_t slave_type(input int i);
    case (i)
      2:       slave_type = 5'h02;
      3:       slave_type = 5'h03;
      11:      slave_type = 5'h04;
      12:      slave_type = 5'h05;
      default: slave_type = 5'h00;
    endcase
  endfunction : slave_type

  ctl_mode_t              mode;
  logic                   slave;
  logic [EXT_PINS-1:0]    ext_meta_ff;
  logic [EXT_PINS-1:0]    ext_sync_ff;
  src_vec_t               pend_ff;
  src_vec_t               serv_ff;
  logic [10:0]            mask_ff;
  level_t                 thr_ff;
  logic [15:0]            reg_rdata_ff;
  logic                   int_req_ff;
  vec_type_t              int_type_ff;
  src_vec_t               live;
  src_vec_t               elig;
  src_vec_t               msk_v;
  src_vec_t               set_v;
  src_vec_t               ack_vec;
  src_vec_t               eoi_clr;
  logic [3*NSRC-1:0]      prio_flat;
  vec_type_t              type_a [NSRC];
  logic [4:0]             best;
  logic [4:0]             top_serv;
  level_t                 best_prio;
  level_t                 top_prio;
  logic [15:0]            poll_word;
  logic                   poll_rd;
  logic                   ack_go;
  logic                   eoi_wr;
  logic                   dis_wr;

  assign mode  = slave_mode_sel ? MODE_SLAVE : MODE_MASTER;
  assign slave = (mode == MODE_SLAVE);

  // Two-stage synchroniser for the external pins
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_meta_ff <= '0;
      ext_sync_ff <= '0;
    end else begin
      ext_meta_ff <= external_request_pins;
      ext_sync_ff <= ext_meta_ff;
    end
  end

  // Per-source priority, mask and type; slave timers 1/2 use slots 4/5
  for (genvar g = 0; g < NSRC; g++) begin : g_src
    localparam int SPOS = (g == 11) ? 4 : ((g == 12) ? 5 : g);
    localparam int MPOS = (g > 10) ? 0 : g;
    assign prio_flat[3*g+:3] = slave ? source_priority_field[3*SPOS+:3]
                                     : source_priority_field[3*MPOS+:3];
    assign msk_v[g]  = slave ? mask_ff[SPOS] : mask_ff[MPOS];
    assign type_a[g] = slave ? slave_type(g) : master_type(g);
  end

  // Request sets for latched internal sources
  always_comb begin
    set_v = '0;
    set_v[0]  = timer_req[0];
    set_v[11] = timer_req[1];
    set_v[12] = timer_req[2];
    set_v[3:2] = dma_req;
    set_v[9]  = serial_enable[1] & (|serial_one_status) & !slave;
    set_v[10] = serial_enable[0] & (|serial_zero_status) & !slave;
  end

  // Present requests: latched flags plus live pin levels
  always_comb begin
    live = pend_ff;
    if (slave) begin
      live[10:4] = 7'h00;
    end else begin
      live[8:4] = ext_sync_ff;
    end
  end

  assign top_serv  = pick_top(serv_ff, prio_flat);
  assign top_prio  = prio_flat[3*top_serv[3:0]+:3];

  // Eligibility: request, not in service, unmasked, at or under threshold
  always_comb begin
    for (int i = 0; i < NSRC; i++) begin
      elig[i] = live[i] & !serv_ff[i] & !msk_v[i]
              & (prio_flat[3*i+:3] <= thr_ff)
              & (!slave || !top_serv[4] || prio_flat[3*i+:3] <= top_prio);
    end
  end

  assign best      = pick_top(elig, prio_flat);
  assign best_prio = prio_flat[3*best[3:0]+:3];

  assign poll_word = best[4] ? {1'b1, 10'h000, type_a[best[3:0]]} : 16'h0000;

  // Bus decode
  assign poll_rd = reg_rd && (reg_addr == `OFS_FETCH_ACK);
  assign eoi_wr  = reg_wr && (reg_addr == `OFS_END_SERVICE);
  assign dis_wr  = reg_wr && (reg_addr == `OFS_DISABLE);

  assign ack_go  = (core_ack | poll_rd) & best[4];
  assign ack_vec = ack_go ? (src_vec_t'(1) << best[3:0]) : '0;

  // End command: non-specific or by type
  always_comb begin
    eoi_clr = '0;
    if (eoi_wr) begin
      if (reg_wdata[`BIT_NONSPEC]) begin
        if (top_serv[4]) begin
          eoi_clr[top_serv[3:0]] = 1'b1;
        end
      end else begin
        for (int i = 0; i < NSRC; i++) begin
          eoi_clr[i] = (type_a[i] == reg_wdata[4:0]);
        end
      end
    end
  end

  // Latched pending flags; a new request beats the acknowledge clear
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_ff <= '0;
    end else begin
      // set on request, clear on ack
      pend_ff <= (pend_ff & ~ack_vec) | set_v;
    end
  end

  // In-service flags; taking an interrupt beats a same-cycle end command
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      serv_ff <= '0;
    end else begin
      // set on take, clear by end
      serv_ff <= (serv_ff & ~eoi_clr) | ack_vec;
    end
  end

  // Global mask, shared with the per-source control registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mask_ff <= `RST_DISABLE;
    end else if (dis_wr) begin
      // bus write; bit 1 held zero
      mask_ff <= reg_wdata[10:0] & `DISABLE_VALID;
    end else begin
      mask_ff <= ((mask_ff & ~ctl_mask_wr) | (ctl_mask_wdata & ctl_mask_wr))
               & `DISABLE_VALID;
    end
  end

  // Priority threshold
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      thr_ff <= `RST_THRESHOLD;
    end else if (reg_wr && reg_addr == `OFS_THRESHOLD) begin
      thr_ff <= reg_wdata[2:0];
    end
  end

  // Read data, valid only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_ff <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `OFS_FETCH_ACK:    reg_rdata_ff <= poll_word;
        `OFS_PEEK:         reg_rdata_ff <= poll_word;
        `OFS_DISABLE:      reg_rdata_ff <= {5'h00, mask_ff};
        `OFS_THRESHOLD:    reg_rdata_ff <= {13'h0000, thr_ff};
        `OFS_SERVICE:      reg_rdata_ff <= reg_view(serv_ff, slave);
        `OFS_REQUEST:      reg_rdata_ff <= reg_view(live, slave);
        `OFS_TIMER_STATUS: reg_rdata_ff <= {13'h0000, pend_ff[12],
                                            pend_ff[11], pend_ff[0]};
        default:           reg_rdata_ff <= 16'h0000;
      endcase
    end else begin
      reg_rdata_ff <= 16'h0000;
    end
  end

  // Request and type presented to the core
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      int_req_ff  <= 1'b0;
      int_type_ff <= 5'h00;
    end else begin
      int_req_ff  <= best[4];
      int_type_ff <= poll_word[4:0];
    end
  end

  assign reg_rdata          = reg_rdata_ff;
  assign int_request        = int_req_ff;
  assign int_type           = int_type_ff;
  assign source_disable_bit = mask_ff;

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence s_poll_read;
    reg_rd && (reg_addr == `OFS_FETCH_ACK);
  endsequence

  sequence s_eoi_nonspec;
    eoi_wr && reg_wdata[`BIT_NONSPEC] && top_serv[4] && !ack_go;
  endsequence

  property p_ack_sets_service;
    src_vec_t v;
    (ack_go, v = ack_vec) |=> ((serv_ff & v) == v);
  endproperty
  a_ack_sets_service: assert property (p_ack_sets_service)
    else $error("taken source not marked in service");

  property p_ack_clears_pend;
    src_vec_t v;
    (ack_go && set_v == '0, v = ack_vec) |=> ((pend_ff & v) == '0);
  endproperty
  a_ack_clears_pend: assert property (p_ack_clears_pend)
    else $error("acknowledge left pending flag set");

  property p_pins_follow;
    (!slave_mode_sel) [*3]
      |-> (live[8:4] == $past(external_request_pins, 2));
  endproperty
  a_pins_follow: assert property (p_pins_follow)
    else $error("pin pending bits do not follow pins");

  property p_threshold;
    best[4] |-> (best_prio <= thr_ff) && !msk_v[best[3:0]];
  endproperty
  a_threshold: assert property (p_threshold)
    else $error("source above threshold or masked was chosen");

  property p_poll_word;
    logic [4:0] b;
    // A back-to-back read may legally refill the data one cycle later
    (s_poll_read, b = best) |=> (reg_rdata_ff[14:5] == 10'h000)
      && (reg_rdata_ff[15] == b[4])
      ##1 ($past(reg_rd) || reg_rdata_ff == 16'h0000);
  endproperty
  a_poll_word: assert property (p_poll_word)
    else $error("poll word layout or timing wrong");

  property p_peek_quiet;
    (reg_rd && reg_addr == `OFS_PEEK && !core_ack)
      |=> (serv_ff == $past(serv_ff));
  endproperty
  a_peek_quiet: assert property (p_peek_quiet)
    else $error("peek read changed in-service flags");

  property p_eoi_nonspec;
    src_vec_t v;
    (s_eoi_nonspec, v = src_vec_t'(1) << top_serv[3:0])
      |=> ((serv_ff & v) == '0);
  endproperty
  a_eoi_nonspec: assert property (p_eoi_nonspec)
    else $error("non-specific end left top in-service bit");

  property p_ctl_mask;
    (|ctl_mask_wr && !dis_wr) |=> (((source_disable_bit
      ^ $past(ctl_mask_wdata)) & $past(ctl_mask_wr) & `DISABLE_VALID) == '0);
  endproperty
  a_ctl_mask: assert property (p_ctl_mask)
    else $error("control mask write not reflected in global mask");

  property p_slave_quiet;
    slave_mode_sel |-> (live[10:4] == 7'h00);
  endproperty
  a_slave_quiet: assert property (p_slave_quiet)
    else $error("pin or serial request seen in slave mode");

  property p_nesting;
    (slave_mode_sel && top_serv[4] && best[4]) |-> (best_prio <= top_prio);
  endproperty
  a_nesting: assert property (p_nesting)
    else $error("lower level admitted while nested");

endmodule : interrupt_pending_service_logic
`default_nettype wire

// ### intc_regs.svh
// Register offsets, field positions, reset values and type codes
// Assumes inclusion by the interrupt pending/service block only
//
// Contract
// - Internal sources latch a pending flag on request; acknowledge clears it.
// - External pin pending bits follow the present pin level, never latched.
// - Pending register read-only; serial 10/9, pins 8-4, DMA 3/2, timers 0.
// - Serial pending bit is the enabled OR of its seven status conditions.
// - Timer group pending is the OR of three timers; status shows each.
// - In-service bit set when taken, held until end command; resets zero.
// - Timer group in-service bit reads as OR of three timer bits.
// - Sources with priority above the threshold are blocked; threshold resets 7.
// - Priority 0 is highest, 7 lowest; threshold 5 admits 0 through 5.
// - Global mask and per-source control mask bits always hold one value.
// - Mask bit 1 disables a source; mask resets to 07FDh.
// - Peek register mirrors the fetch register and has no side effect.
// - Reading the fetch register acknowledges the best pending request.
// - Poll word: bit 15 valid, bits 4-0 type, bits 14-5 zero.
// - Poll acknowledge sets in-service but does not vector the processor.
// - End command write-only; bit 15 set non-specific, else type in 4-0.
// - Master mode after reset; slave mode only with relocation bit 14 set.
// - Slave mode ignores pins; each timer has own mask and in-service bit.
// - Slave mode: fifth pin and both serial sources never request.
// - Slave mode blocks levels lower than the highest one in service.
// - Timer status register bits 2-0 show each timer's pending request.
`ifndef INTC_REGS_SVH
`define INTC_REGS_SVH

`define OFS_END_SERVICE   8'h22
`define OFS_FETCH_ACK     8'h24
`define OFS_PEEK          8'h26
`define OFS_DISABLE       8'h28
`define OFS_THRESHOLD     8'h2A
`define OFS_SERVICE       8'h2C
`define OFS_REQUEST       8'h2E
`define OFS_TIMER_STATUS  8'h30

`define RST_DISABLE       11'h7FD
`define RST_THRESHOLD     3'h7
`define DISABLE_VALID     11'h7FD
`define BIT_VALID         15
`define BIT_NONSPEC       15

`define TYPE_TMR0         5'h08
`define TYPE_TMR1         5'h12
`define TYPE_TMR2         5'h13
`define TYPE_DMA0         5'h0A
`define TYPE_DMA1         5'h0B
`define TYPE_EXT0         5'h0C
`define TYPE_EXT1         5'h0D
`define TYPE_EXT2         5'h0E
`define TYPE_EXT3         5'h0F
`define TYPE_EXT4         5'h10
`define TYPE_SER1         5'h11
`define TYPE_SER0         5'h14

`endif

// ### intc_pkg.sv
// Types shared by the interrupt pending/service block
// Assumes intc_regs.svh supplies the numeric constants
`default_nettype none
package intc_pkg;
  typedef logic [12:0] src_vec_t;
  typedef logic [2:0]  level_t;
  typedef logic [4:0]  vec_type_t;
  typedef enum logic [1:0] {
    MODE_MASTER = 2'b01,
    MODE_SLAVE  = 2'b10
  } ctl_mode_t;
endpackage : intc_pkg
`default_nettype wire

// ### periph_model.sv
// Stand-in for the external pins and the processor core acknowledge
// Assumes one clock; a raised pin stays high until its pin_serviced bit clears it
`timescale 1ns/10ps
`default_nettype none
module periph_model (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  // Scenario controls
  input  wire logic [4:0] pin_raise,
  input  wire logic [4:0] pin_serviced,
  input  wire logic       ack_en,
  input  wire logic [3:0] ack_delay,
  // Block side
  input  wire logic       int_request,
  output logic      [4:0] external_request_pins,
  output logic            core_ack
);
  logic [3:0] wait_ff;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b)
      external_request_pins <= 5'h00;
    else
      external_request_pins <= (external_request_pins | pin_raise)
                               & ~pin_serviced;
  end

  // Core acknowledges after a chosen number of request cycles
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_ff  <= 4'h0;
      core_ack <= 1'b0;
    end else begin
      core_ack <= 1'b0;
      if (!ack_en || !int_request || core_ack) begin
        wait_ff <= 4'h0;
      end else if (wait_ff == ack_delay) begin
        core_ack <= 1'b1;
        wait_ff  <= 4'h0;
      end else begin
        wait_ff <= wait_ff + 4'h1;
      end
    end
  end
endmodule : periph_model
`default_nettype wire

// ### tb.sv
// Self-checking bench for the interrupt pending/service block
// Assumes the peripheral model drives pins and core acknowledge
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        core_clk;
  logic        rst_b;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic [2:0]  timer_req;
  logic [1:0]  dma_req;
  logic [6:0]  serial_zero_status;
  logic [6:0]  serial_one_status;
  logic [1:0]  serial_enable;
  logic [4:0]  external_request_pins;
  logic [32:0] prio;
  logic [10:0] ctl_mask_wr;
  logic [10:0] ctl_mask_wdata;
  logic [10:0] source_disable_bit;
  logic        slave_mode_sel;
  logic        core_ack;
  logic        int_request;
  logic [4:0]  int_type;
  logic [4:0]  pin_raise;
  logic [4:0]  pin_serviced;
  logic        ack_en;
  logic [3:0]  ack_delay;
  logic [15:0] rd_val;
  int          err_count;
  int          total_checks;
  int          cyc;

  // Design and its surroundings
  interrupt_pending_service_logic u_interrupt_pending_service_logic (
    .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .timer_req(timer_req), .dma_req(dma_req),
    .serial_zero_status(serial_zero_status),
    .serial_one_status(serial_one_status), .serial_enable(serial_enable),
    .external_request_pins(external_request_pins),
    .source_priority_field(prio), .ctl_mask_wr(ctl_mask_wr),
    .ctl_mask_wdata(ctl_mask_wdata),
    .source_disable_bit(source_disable_bit),
    .slave_mode_sel(slave_mode_sel), .core_ack(core_ack),
    .int_request(int_request), .int_type(int_type));
  periph_model u_periph_model (
    .core_clk(core_clk), .rst_b(rst_b), .pin_raise(pin_raise),
    .pin_serviced(pin_serviced), .ack_en(ack_en), .ack_delay(ack_delay),
    .int_request(int_request),
    .external_request_pins(external_request_pins), .core_ack(core_ack));

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
  endtask : step

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read strobe, data taken in the following cycle, then compared
  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
    check(rd_val, e);
  endtask : rdc

  task automatic t_reset;
    rdc(8'h28, 16'h07FD);
    rdc(8'h2A, 16'h0007);
    rdc(8'h2C, 16'h0000);
    rdc(8'h26, 16'h0000);
    rdc(8'h22, 16'h0000);
    rdc(8'h40, 16'h0000);
    check({5'h00, source_disable_bit}, 16'h07FD);
    $display("reset test done");
  endtask : t_reset

  task automatic t_regs;
    wr(8'h28, 16'hFFFF);
    rdc(8'h28, 16'h07FD);
    @(posedge core_clk);
    ctl_mask_wr    <= 11'h004;
    ctl_mask_wdata <= 11'h000;
    @(posedge core_clk);
    ctl_mask_wr <= 11'h000;
    rdc(8'h28, 16'h07F9);
    wr(8'h28, 16'h0000);
    #1;
    check({5'h00, source_disable_bit}, 16'h0000);
    wr(8'h2A, 16'hFFF5);
    rdc(8'h2A, 16'h0005);
    wr(8'h2C, 16'hFFFF);
    rdc(8'h2C, 16'h0000);
    wr(8'h2A, 16'h0007);
    $display("register test done");
  endtask : t_regs

  task automatic t_poll;
    @(posedge core_clk);
    prio[2:0] <= 3'h3;
    prio[8:6] <= 3'h1;
    timer_req <= 3'h1;
    dma_req   <= 2'h1;
    @(posedge core_clk);
    timer_req <= 3'h0;
    dma_req   <= 2'h0;
    rdc(8'h2E, 16'h0005);
    rdc(8'h30, 16'h0001);
    rdc(8'h26, 16'h800A);
    rdc(8'h26, 16'h800A);
    rdc(8'h24, 16'h800A);
    rdc(8'h2C, 16'h0004);
    rdc(8'h2E, 16'h0001);
    rdc(8'h26, 16'h8008);
    rdc(8'h24, 16'h8008);
    rdc(8'h2C, 16'h0005);
    wr(8'h22, 16'h8000);
    rdc(8'h2C, 16'h0001);
    wr(8'h22, 16'h0008);
    rdc(8'h2C, 16'h0000);
    $display("poll test done");
  endtask : t_poll

  task automatic t_level;
    int n;
    n = 0;
    @(posedge core_clk);
    prio[2:0] <= 3'h6;
    ack_delay <= 4'h6;
    ack_en    <= 1'b1;
    wr(8'h2A, 16'h0005);
    @(posedge core_clk);
    timer_req <= 3'h2;
    @(posedge core_clk);
    timer_req <= 3'h0;
    rdc(8'h26, 16'h0000);
    check({15'h0000, int_request}, 16'h0000);
    wr(8'h2A, 16'h0006);
    while (int_request !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check({11'h000, int_type}, 16'h0012);
    step(12);
    rdc(8'h2C, 16'h0001);
    rdc(8'h2E, 16'h0000);
    wr(8'h22, 16'h0012);
    rdc(8'h2C, 16'h0000);
    ack_en <= 1'b0;
    wr(8'h2A, 16'h0007);
    $display("threshold test done");
  endtask : t_level

  task automatic t_pins;
    @(posedge core_clk);
    prio[14:12] <= 3'h2;
    pin_raise   <= 5'h04;
    @(posedge core_clk);
    pin_raise <= 5'h00;
    step(4);
    rdc(8'h2E, 16'h0040);
    rdc(8'h24, 16'h800E);
    rdc(8'h2E, 16'h0040);
    @(posedge core_clk);
    pin_serviced <= 5'h04;
    @(posedge core_clk);
    pin_serviced <= 5'h00;
    step(4);
    rdc(8'h2E, 16'h0000);
    wr(8'h22, 16'h000E);
    rdc(8'h2C, 16'h0000);
    $display("pin test done");
  endtask : t_pins

  task automatic t_serial;
    @(posedge core_clk);
    prio[32:30]       <= 3'h1;
    serial_enable     <= 2'b01;
    serial_one_status <= 7'h7F;
    for (int i = 0; i < 7; i++) begin
      @(posedge core_clk);
      serial_zero_status <= 7'h01 << i;
      @(posedge core_clk);
      serial_zero_status <= 7'h00;
      rdc(8'h2E, 16'h0400);
      rdc(8'h24, 16'h8014);
      wr(8'h22, 16'h0014);
    end
    // Port 1 and DMA1 together; equal levels fall to the lower index
    @(posedge core_clk);
    serial_enable <= 2'b10;
    dma_req       <= 2'h2;
    @(posedge core_clk);
    serial_enable <= 2'b00;
    dma_req       <= 2'h0;
    rdc(8'h2E, 16'h0208);
    rdc(8'h24, 16'h800B);
    rdc(8'h24, 16'h8011);
    wr(8'h22, 16'h8000);
    rdc(8'h2C, 16'h0200);
    wr(8'h22, 16'h0011);
    rdc(8'h2C, 16'h0000);
    @(posedge core_clk);
    serial_enable      <= 2'b00;
    serial_zero_status <= 7'h7F;
    step(2);
    rdc(8'h2E, 16'h0000);
    $display("serial test done");
  endtask : t_serial

  task automatic t_slave;
    @(posedge core_clk);
    slave_mode_sel     <= 1'b1;
    prio[2:0]          <= 3'h2;
    prio[8:6]          <= 3'h3;
    prio[17:15]        <= 3'h4;
    serial_enable      <= 2'b11;
    serial_one_status  <= 7'h01;
    serial_zero_status <= 7'h01;
    pin_raise          <= 5'h1F;
    @(posedge core_clk);
    pin_raise <= 5'h00;
    step(4);
    rdc(8'h2E, 16'h0000);
    @(posedge core_clk);
    timer_req <= 3'h5;
    @(posedge core_clk);
    timer_req <= 3'h0;
    rdc(8'h2E, 16'h0021);
    rdc(8'h24, 16'h8000);
    rdc(8'h26, 16'h0000);
    wr(8'h22, 16'h8000);
    rdc(8'h26, 16'h8005);
    $display("slave test done");
  endtask : t_slave

  // Free-running clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 6000) begin
      err_count++;
      print_verdict;
    end
  end

  // Main sequence
  initial begin
    rst_b = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    timer_req = 3'h0;
    dma_req = 2'h0;
    serial_zero_status = 7'h00;
    serial_one_status = 7'h00;
    serial_enable = 2'b00;
    prio = 33'h1_FFFF_FFFF;
    ctl_mask_wr = 11'h000;
    ctl_mask_wdata = 11'h000;
    slave_mode_sel = 1'b0;
    pin_raise = 5'h00;
    pin_serviced = 5'h00;
    ack_en = 1'b0;
    ack_delay = 4'h0;
    err_count = 0;
    total_checks = 0;
    cyc = 0;
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    t_reset;
    t_regs;
    t_poll;
    t_level;
    t_pins;
    t_serial;
    t_slave;
    print_verdict;
  end
endmodule : tb
`default_nettype wire
